// ---- inc/flsp_pkg.sv ----
// flsp_pkg: constants and types of the flash status and write-protect block
package flsp_pkg;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int          ADDR_W = 23;                  // 8 MB array
  localparam logic [22:0] ADDR_ONES = 23'h7FFFFF;
  localparam logic [22:0] ADDR_ZERO = 23'h000000;

  // ----------------------------------------
  // status register one bit positions
  // ----------------------------------------
  localparam int SR1_BUSY   = 0;
  localparam int SR1_WEL    = 1;
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_BP_MSB = 6;
  localparam int SR1_REG_PROTECT_LO   = 7;

  // ----------------------------------------
  // status register two bit positions (within its byte)
  // ----------------------------------------
  localparam int SR2_OFS    = 8;                        // register two sits above register one
  localparam int SR2_REG_PROTECT_HI   = 0;
  localparam int SR2_QE     = 1;
  localparam int SR2_PROGRAM_SUSPENDED   = 2;
  localparam int SR2_LB_LSB = 3;
  localparam int SR2_LB_MSB = 5;
  localparam int SR2_CMP    = 6;
  localparam int SR2_ERASE_SUSPENDED   = 7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0] BP_RST  = 5'h00;
  localparam logic [2:0] LB_RST  = 3'h0;
  localparam logic       BIT_RST = 1'b0;

  // ----------------------------------------
  // protection decoder constants
  // ----------------------------------------
  localparam logic [2:0] BP_NONE        = 3'h0;        // low code selecting nothing
  localparam logic [2:0] BP_ALL         = 3'h7;        // low code selecting everything
  localparam logic [2:0] BP_SMALL_MAX   = 3'h4;        // 32 KB is the largest small area
  localparam logic [4:0] BIG_BASE_LOG2  = 5'h10;       // code n gives 2^(16+n) bytes
  localparam logic [4:0] SMALL_BASE_LOG2 = 5'h0B;      // code n gives 2^(11+n) bytes

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_SRW   = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h2,
    OP_CHIP  = 2'h3
  } flsp_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1
  } flsp_state_type;

endpackage

// ---- core/flsp_status_protect.sv ----
// flsp_status_protect: status registers, write-enable latch and array protection gate
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RULE1) SR1: reg_protect_lo, five area bits, latch, busy
// (RULE2) SR2: suspends, complement, locks, quad, reg_protect_hi
// (RULE3) busy reads 1 during any write operation
// (RULE4) latch clear refuses status writes, program, erase
// (RULE5) area bits change only by status write
// (RULE6) protected target address refuses program/erase
// (RULE7) area bits writable only outside hardware lock
// (RULE8) complement 0: small bottom areas decode
// (RULE9) complement 1: lower fractions, all, none
// (RULE10) complement 1: upper fractions of array
// (RULE11) complement 1: all below small top area
// (RULE12) complement 1: all above small bottom area
// (RULE13) lock bits once set never clear; the code clears them on reset
// (RULE14) latch cleared by reset, disable, writes, erases
// (RULE15) write-protect low locks area and srp bits
// (RULE16) srp 01 with pin low refuses status writes
// (RULE17) chip erase only on none/all low codes
// (RULE18) decoder is combinational on current bits
module flsp_status_protect (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // write-protect pin
  input  wire logic               wp_n,
  // decoded commands, one-cycle pulses
  input  wire logic               write_enable_cmd,
  input  wire logic               write_disable_cmd,
  input  wire logic               status_write_cmd,
  input  wire logic [15:0]        status_wdata,
  input  wire logic               page_program_cmd,
  input  wire logic               sector_erase_cmd,
  input  wire logic               block_erase_cmd,
  input  wire logic               chip_erase_cmd,
  input  wire logic [22:0]        cmd_addr,
  input  wire logic               soft_reset_cmd,
  // array engine events
  input  wire logic               erase_suspend_evt,
  input  wire logic               program_suspend_evt,
  input  wire logic               resume_evt,
  input  wire logic               op_done,
  // status and launch outputs
  output logic [7:0]              status_low,
  output logic [7:0]              status_high,
  output logic                    op_start,
  output flsp_pkg::flsp_op_type   op_kind,
  output logic                    cmd_refused
);
  import flsp_pkg::*;

  flsp_state_type state_reg, state_next;
  flsp_op_type    kind_reg, kind_next;
  logic [4:0]     bp_reg, bp_next;
  logic [2:0]     lb_reg, lb_next;
  logic           reg_protect_lo_reg, reg_protect_lo_next, reg_protect_hi_reg, reg_protect_hi_next;
  logic           qe_reg, qe_next, cmp_reg, cmp_next;
  logic           wel_reg, wel_next;
  logic           erase_suspended_reg, erase_suspended_next, program_suspended_reg, program_suspended_next;
  logic           start_reg, start_next, refused_reg, refused_next;
  logic           idle, any_cmd, addr_prot, chip_ok, sr_locked;

  // ----------------------------------------
  // protection decoder
  // ----------------------------------------
  // area in range for complement 0; complement 1 is its exact inverse,
  // which covers every row of both tables with one comparator pair
  function automatic logic prot_hit(input logic [4:0] bp, input logic cmp,
                                    input logic [22:0] addr);
    logic [2:0]  n;
    logic [4:0]  k;
    logic [22:0] mask;
    logic        inr;
    n = bp[2:0];
    if (bp[4]) begin
      k = SMALL_BASE_LOG2 + {2'h0, ((n > BP_SMALL_MAX) ? BP_SMALL_MAX : n)}; // RULE8 RULE11 RULE12
    end else begin
      k = BIG_BASE_LOG2 + {2'h0, n};                                       // RULE9 RULE10
    end
    mask = ~(ADDR_ONES << k);
    if (n == BP_NONE) begin
      inr = 1'b0;
    end else if (n == BP_ALL) begin
      inr = 1'b1;
    end else if (bp[3]) begin
      inr = ((addr & ~mask) == ADDR_ZERO);                                 // bottom areas
    end else begin
      inr = ((addr | mask) == ADDR_ONES);                                  // top areas
    end
    return inr ^ cmp;                                                      // RULE9 RULE10
  endfunction

  // decoder follows live bits, so a new setting gates the next command
  assign addr_prot = prot_hit(bp_reg, cmp_reg, cmd_addr);                 // RULE18
  assign chip_ok   = ((bp_reg[2:0] == BP_NONE) && !cmp_reg) ||
                     ((bp_reg[2:0] == BP_ALL) && cmp_reg);                 // RULE17
  // srp 10/11 lock until reset; srp 01 locks while the pin is low
  assign sr_locked = reg_protect_hi_reg | (reg_protect_lo_reg & ~wp_n);                        // RULE15 RULE16
  assign idle      = (state_reg == ST_IDLE);
  assign any_cmd   = status_write_cmd | page_program_cmd | sector_erase_cmd |
                     block_erase_cmd | chip_erase_cmd;

  // ----------------------------------------
  // command acceptance and status bits
  // ----------------------------------------
  // commands arriving while busy, except write disable and soft reset, are
  // dropped silently, as the array engine cannot take a second operation
  always_comb begin
    state_next   = state_reg;
    kind_next    = kind_reg;
    bp_next      = bp_reg;
    lb_next      = lb_reg;
    reg_protect_lo_next    = reg_protect_lo_reg;
    reg_protect_hi_next    = reg_protect_hi_reg;
    qe_next      = qe_reg;
    cmp_next     = cmp_reg;
    wel_next     = wel_reg;
    start_next   = 1'b0;
    refused_next = 1'b0;
    if (idle && write_enable_cmd) begin
      wel_next = 1'b1;
    end
    if (write_disable_cmd || soft_reset_cmd) begin
      wel_next = 1'b0;                                                     // RULE14
    end
    if (idle && any_cmd) begin
      if (!wel_reg) begin
        refused_next = 1'b1;                                               // RULE4
      end else begin
        wel_next = 1'b0;                                                   // RULE14
        if (status_write_cmd) begin
          if (sr_locked) begin
            refused_next = 1'b1;                                           // RULE7 RULE16
          end else begin
            // busy, latch and suspend bits ignore the written data; lock bits only set
            bp_next    = status_wdata[SR1_BP_MSB:SR1_BP_LSB];              // RULE5
            reg_protect_lo_next  = status_wdata[SR1_REG_PROTECT_LO];
            reg_protect_hi_next  = status_wdata[SR2_OFS + SR2_REG_PROTECT_HI];
            qe_next    = status_wdata[SR2_OFS + SR2_QE];
            cmp_next   = status_wdata[SR2_OFS + SR2_CMP];
            lb_next    = lb_reg |
                         status_wdata[SR2_OFS + SR2_LB_MSB:SR2_OFS + SR2_LB_LSB]; // RULE13
            start_next = 1'b1;
            kind_next  = OP_SRW;
          end
        end else if (chip_erase_cmd) begin
          refused_next = !chip_ok;                                         // RULE17
          start_next   = chip_ok;
          kind_next    = OP_CHIP;
        end else begin
          refused_next = addr_prot;                                        // RULE6
          start_next   = !addr_prot;
          kind_next    = page_program_cmd ? OP_PROG : OP_ERASE;
        end
      end
    end
    // busy until the engine reports completion
    case (state_reg)
      ST_IDLE: begin
        if (start_next) begin
          state_next = ST_BUSY;                                            // RULE3
        end
      end
      ST_BUSY: begin
        if (op_done) begin
          state_next = ST_IDLE;                                            // RULE3
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // suspend flags
  // ----------------------------------------
  // set wins over a resume or reset in the same cycle
  always_comb begin
    erase_suspended_next = erase_suspended_reg;
    program_suspended_next = program_suspended_reg;
    if (resume_evt || soft_reset_cmd) begin
      erase_suspended_next = 1'b0;
      program_suspended_next = 1'b0;
    end
    if (erase_suspend_evt) begin
      erase_suspended_next = 1'b1;
    end
    if (program_suspend_evt) begin
      program_suspended_next = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reset stands in for power-up, so every bit returns to its default
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      kind_reg    <= OP_SRW;
      bp_reg      <= BP_RST;
      lb_reg      <= LB_RST;
      reg_protect_lo_reg    <= BIT_RST;
      reg_protect_hi_reg    <= BIT_RST;
      qe_reg      <= BIT_RST;
      cmp_reg     <= BIT_RST;
      wel_reg     <= BIT_RST;                                              // RULE14
      erase_suspended_reg    <= BIT_RST;
      program_suspended_reg    <= BIT_RST;
      start_reg   <= BIT_RST;
      refused_reg <= BIT_RST;
    end else begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      bp_reg      <= bp_next;
      lb_reg      <= lb_next;
      reg_protect_lo_reg    <= reg_protect_lo_next;
      reg_protect_hi_reg    <= reg_protect_hi_next;
      qe_reg      <= qe_next;
      cmp_reg     <= cmp_next;
      wel_reg     <= wel_next;
      erase_suspended_reg    <= erase_suspended_next;
      program_suspended_reg    <= program_suspended_next;
      start_reg   <= start_next;
      refused_reg <= refused_next;
    end
  end

  // ----------------------------------------
  // outputs, each bit straight from a flop
  // ----------------------------------------
  // busy is bit 0 of the state code, so the flag comes from a flop directly
  assign status_low  = {reg_protect_lo_reg, bp_reg, wel_reg, state_reg[0]};          // RULE1 RULE3
  assign status_high = {erase_suspended_reg, cmp_reg, lb_reg, program_suspended_reg, qe_reg, reg_protect_hi_reg}; // RULE2
  assign op_start    = start_reg;
  assign op_kind     = kind_reg;
  assign cmd_refused = refused_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence seq_cmd_idle;
    idle && any_cmd;
  endsequence

  sequence seq_srw_taken;
    idle && status_write_cmd && wel_reg && !sr_locked;
  endsequence

  a_wel_refuse: assert property (seq_cmd_idle ##0 !wel_reg |=> !op_start && cmd_refused) // RULE4
    else $error("command taken with latch clear");
  a_busy_start: assert property (op_start |-> status_low[SR1_BUSY] && !status_low[SR1_WEL]) // RULE3
    else $error("operation started without busy");
  a_busy_clear: assert property (!idle && op_done |=> !status_low[SR1_BUSY]) // RULE3
    else $error("busy stuck after completion");
  a_prot_refuse: assert property (seq_cmd_idle ##0 wel_reg && !status_write_cmd && !chip_erase_cmd
                                  && addr_prot |=> cmd_refused && !op_start) // RULE6
    else $error("protected address not refused");
  a_lock_sticky: assert property ((status_high[SR2_LB_MSB:SR2_LB_LSB]
                                  & $past(status_high[SR2_LB_MSB:SR2_LB_LSB]))
                                  == $past(status_high[SR2_LB_MSB:SR2_LB_LSB])) // RULE13
    else $error("lock bit returned to zero");
  a_srw_wel_clr: assert property (seq_srw_taken |=> !status_low[SR1_WEL] ##0 op_start
                                  ##1 status_low[SR1_BUSY]) // RULE14
    else $error("status write did not clear latch");
  a_hw_lock: assert property (idle && status_write_cmd && sr_locked
                              |=> $stable(status_low[SR1_BP_MSB:SR1_BP_LSB])
                              && $stable(status_low[SR1_REG_PROTECT_LO])) // RULE15
    else $error("locked status register changed");
  a_chip_gate: assert property (seq_cmd_idle ##0 wel_reg && chip_erase_cmd && !status_write_cmd
                                && !chip_ok |=> !op_start) // RULE17
    else $error("chip erase ran under protection");

endmodule

`default_nettype wire

// ---- tb/flsp_engine_model.sv ----
// flsp_engine_model: array engine stand-in that ends each launched operation
`timescale 1ns/10ps
`default_nettype none
module flsp_engine_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // launch from the block and pace select
  input  wire logic op_start,
  input  wire logic slow,
  // completion pulse back to the block
  output logic      op_done
);
  int cnt;

  // ----------------------------------------
  // completion timer
  // ----------------------------------------
  // a slow run leaves room to poke the block while it is busy
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt     <= 0;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (op_start) begin
        cnt <= slow ? 40 : 2;
      end else if (cnt == 1) begin
        cnt     <= 0;
        op_done <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/flash_status_write_protect_tb.sv ----
// flash_status_write_protect_tb: self-checking bench of the status and protect block
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect_tb;
  import flsp_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wp_n = 1'b1;
  logic        slow = 1'b0;
  logic [10:0] pl = 11'h000;
  logic [15:0] sd = 16'h0000;
  logic [22:0] ad = 23'h000000;
  logic [7:0]  status_low, status_high, lo, hi;
  logic        op_start, cmd_refused, op_done;
  flsp_op_type op_kind;
  logic [15:0] d;
  logic [22:0] a;
  int          fail_count = 0, n_checks = 0, seed = 79188, cyc = 0;
  // hand-picked code and address pairs at area edges
  logic [28:0] cz [10] = '{{5'h1B, 1'b0, 23'h003FFF}, {5'h1C, 1'b0, 23'h008000},
    {5'h01, 1'b1, 23'h7DFFFF}, {5'h01, 1'b1, 23'h7E0000}, {5'h09, 1'b1, 23'h01FFFF},
    {5'h0E, 1'b1, 23'h400000}, {5'h11, 1'b1, 23'h7FF000}, {5'h11, 1'b1, 23'h7FEFFF},
    {5'h19, 1'b1, 23'h000FFF}, {5'h18, 1'b1, 23'h7FFFFF}};

  // clock, 50 ns period
  always #25 core_clk = ~core_clk;

  // ----------------------------------------
  // design and engine model
  // ----------------------------------------
  flsp_status_protect flsp_status_protect_inst (
    .core_clk(core_clk), .rstn(rstn), .wp_n(wp_n),
    .write_enable_cmd(pl[0]), .write_disable_cmd(pl[1]), .status_write_cmd(pl[2]),
    .status_wdata(sd), .page_program_cmd(pl[3]), .sector_erase_cmd(pl[4]),
    .block_erase_cmd(pl[5]), .chip_erase_cmd(pl[6]), .cmd_addr(ad),
    .soft_reset_cmd(pl[7]), .erase_suspend_evt(pl[8]), .program_suspend_evt(pl[9]),
    .resume_evt(pl[10]), .op_done(op_done), .status_low(status_low),
    .status_high(status_high), .op_start(op_start), .op_kind(op_kind),
    .cmd_refused(cmd_refused));
  flsp_engine_model flsp_engine_model_inst (
    .core_clk(core_clk), .rstn(rstn), .op_start(op_start), .slow(slow), .op_done(op_done));

  // watchdog: the run needs well under this many cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one command pulse; returns just after the edge that answers it
  task automatic cmd(input int k, input logic [15:0] dv, input logic [22:0] av);
    @(posedge core_clk);
    pl <= 11'h001 << k;
    sd <= dv;
    ad <= av;
    @(posedge core_clk);
    pl <= 11'h000;
    #1;
  endtask

  // bounded wait for busy to drop; a stuck or unknown busy counts as a mismatch
  task automatic idle();
    int n;
    n = 0;
    while (status_low[0] !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 100) fail_count++;
  endtask

  // protected area from the area code; complement 1 inverts the whole map
  function automatic logic prot(input logic [4:0] b, input logic c, input logic [22:0] av);
    logic [2:0] l;
    int         sz;
    logic       in;
    l = b[2:0];
    sz = b[4] ? (1 << (11 + ((l > 3'h4) ? 4 : l))) : (1 << (16 + l));
    in = b[3] ? (av < sz) : (av >= 24'h800000 - sz);
    if (l == 3'h0) in = 1'b0;
    if (l == 3'h7) in = 1'b1;
    return in ^ c;
  endfunction

  task automatic wr(input logic [15:0] dv, input logic ok);
    cmd(0, 16'h0000, 23'h000000);
    chk(status_low[1], 1'b1);
    cmd(2, dv, 23'h000000);
    chk({op_start, cmd_refused}, ok ? 2'h2 : 2'h1);
    if (ok) begin
      lo = {dv[7:2], 2'h1};
      hi = (hi & 8'hBC) | (dv[15:8] & 8'h7B);
      chk(op_kind, OP_SRW);
    end
    chk({status_high, status_low}, {hi, lo});
    idle();
    lo[0] = 1'b0;
    chk(status_low, lo);
  endtask

  task automatic pe(input int k, input logic [22:0] av);
    logic       p;
    logic [2:0] l;
    l = lo[4:2];
    if (k == 6) p = !((l == 3'h0 && !hi[6]) || (l == 3'h7 && hi[6]));
    else p = prot(lo[6:2], hi[6], av);
    cmd(0, 16'h0000, 23'h000000);
    cmd(k, 16'h0000, av);
    chk({op_start, cmd_refused}, p ? 2'h1 : 2'h2);
    if (!p) chk(op_kind, k == 6 ? OP_CHIP : (k == 3 ? OP_PROG : OP_ERASE));
    chk(status_low[1:0], {1'b0, !p});
    idle();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    lo = 8'h00;
    hi = 8'h00;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({status_high, status_low}, 16'h0000);
    cmd(3, 16'h0000, 23'h7FFFFF);
    chk({op_start, cmd_refused}, 2'h1);
    cmd(2, 16'h4004, 23'h000000);
    chk({status_high, status_low}, 16'h0000);
    cmd(0, 16'h0000, 23'h000000);
    cmd(1, 16'h0000, 23'h000000);
    chk(status_low, 8'h00);
    // a first slow program is launched and waited out to completion
    slow <= 1'b1;
    pe(3, 23'h123456);
    // launch a second slow program, then poke the block while it runs
    cmd(0, 16'h0000, 23'h000000);
    cmd(3, 16'h0000, 23'h123456);
    chk({op_start, cmd_refused}, 2'h2);
    cmd(0, 16'h0000, 23'h000000);
    cmd(3, 16'h0000, 23'h123456);
    chk({op_start, cmd_refused, status_low[1:0]}, 4'h1);
    idle();
    // edge pairs first, then random settings and targets
    for (int i = 0; i < 70; i++) begin
      if (i < 10) begin
        d = {1'b0, cz[i][23], 6'h00, 1'b0, cz[i][28:24], 2'h0};
        a = cz[i][22:0];
      end else begin
        d = 16'($random(seed));
        d[8] = 1'b0;
        d[7] = 1'b0;
        a = 23'($random(seed));
      end
      slow <= i[0];
      wr(d, 1'b1);
      pe((i < 10) ? 3 : 3 + (i % 4), a);
    end
    // suspend flags set, resume and soft reset clear them
    cmd(8, 16'h0000, 23'h000000);
    cmd(9, 16'h0000, 23'h000000);
    chk(status_high & 8'h84, 8'h84);
    cmd(10, 16'h0000, 23'h000000);
    chk(status_high & 8'h84, 8'h00);
    cmd(8, 16'h0000, 23'h000000);
    cmd(0, 16'h0000, 23'h000000);
    cmd(7, 16'h0000, 23'h000000);
    chk({status_high[7], status_low[1]}, 2'h0);
    // pin lock with reg_protect_lo, then lock-down with reg_protect_hi
    wr(16'h0080, 1'b1);
    @(posedge core_clk);
    wp_n <= 1'b0;
    wr(16'h407C, 1'b0);
    @(posedge core_clk);
    wp_n <= 1'b1;
    wr(16'h0100, 1'b1);
    wr(16'h0000, 1'b0);
    // reset in mid-run returns every bit to zero
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({status_high, status_low}, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
